// ==== wb_pattern_defines.vh ====
/*
 * register map, field positions and reset values of the white-balance,
 * black frame, mute and test pattern block.
 * assumes a 32-bit apb slave with one register per aligned word.
 */
`ifndef WB_PATTERN_DEFINES_VH
`define WB_PATTERN_DEFINES_VH

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_GAIN        8'h04
`define OFS_BRIGHT_R    8'h08
`define OFS_BRIGHT_G    8'h0c
`define OFS_BRIGHT_B    8'h10
`define OFS_BF_LEVEL    8'h14
`define OFS_BF_H        8'h18
`define OFS_BF_V        8'h1c
`define OFS_MUTE_R      8'h20
`define OFS_MUTE_G      8'h24
`define OFS_MUTE_B      8'h28
`define OFS_EFF_H       8'h2c
`define OFS_EFF_V       8'h30
`define OFS_WIN_H       8'h34
`define OFS_WIN_V       8'h38
`define OFS_LEVA_R      8'h3c
`define OFS_LEVA_G      8'h40
`define OFS_LEVA_B      8'h44
`define OFS_LEVB_R      8'h48
`define OFS_LEVB_G      8'h4c
`define OFS_LEVB_B      8'h50
`define OFS_PERIOD      8'h54
`define OFS_STATUS      8'h58

// control register fields
`define CTRL_BF_EN      0
`define CTRL_MUTE_EN    1
`define CTRL_PAT_EN     2
`define CTRL_COL_EN_LO  3
`define CTRL_SWAP_LO    6
`define CTRL_DIAG       9
`define CTRL_STAIR      10
`define CTRL_CODE_LO    12

// start in low half, stop in high half of range registers
`define RANGE_STOP_LO   16

// reset values
`define RST_GAIN        8'h40
`define RST_BRIGHT      11'h000
`define RST_LEVEL       10'h000

// pattern codes
`define PAT_RASTER      3'h0
`define PAT_WINDOW      3'h1
`define PAT_VSTRIPE     3'h2
`define PAT_HSTRIPE     3'h3
`define PAT_CROSS       3'h4
`define PAT_DOTS        3'h5
`define PAT_HRAMP       3'h6
`define PAT_VRAMP       3'h7

`endif

// ==== wb_pattern.v ====
/*
 * white-balance gain and bright, black frame, mute and test pattern
 * generator for an rgb pixel stream, with apb register access.
 * assumes pixel data and dot/line positions arrive on clk from the
 * upstream stage and timing generator, qualified by pix_valid.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wb_pattern_defines.vh"

module wb_pattern #(
	parameter PW = 10,	// pixel width
	parameter CW = 11	// position counter width
) (
	input  wire          clk,        // pixel clock, 100 mhz
	input  wire          arst_n,     // async reset, active low
	input  wire          psel,       // apb select
	input  wire          penable,    // apb access phase
	input  wire          pwrite,     // apb write
	input  wire [7:0]    paddr,      // apb byte address
	input  wire [31:0]   pwdata,     // apb write data
	output reg  [31:0]   prdata,     // apb read data
	output reg           pready,     // apb ready
	output reg           pslverr,    // apb error, unmapped address
	input  wire          pix_valid,  // pixel qualifier
	input  wire [PW-1:0] pix_in_r,   // red in
	input  wire [PW-1:0] pix_in_g,   // green in
	input  wire [PW-1:0] pix_in_b,   // blue in
	input  wire [CW-1:0] dot_pos,    // dot position in line
	input  wire [CW-1:0] line_pos,   // line position in frame
	output reg           out_valid,  // output qualifier
	output reg  [PW-1:0] pix_out_r,  // red out
	output reg  [PW-1:0] pix_out_g,  // green out
	output reg  [PW-1:0] pix_out_b   // blue out
);

	// reset synchroniser
	reg rst_meta_reg;	// first stage, read only by second
	reg rst_n_reg;		// synchronised reset
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	// register storage, index 0 red, 1 green, 2 blue
	reg [31:0]   ctrl_reg;	// enables, code, selects
	reg [7:0]    gain_reg    [0:2];	// gain coefficients
	reg [10:0]   bright_reg  [0:2];	// bright coefficients
	reg [PW-1:0] mute_reg    [0:2];	// mute levels
	reg [PW-1:0] leva_reg    [0:2];	// pattern level a
	reg [PW-1:0] levb_reg    [0:2];	// pattern level b
	reg [PW-1:0] bf_level_reg;	// black frame level
	reg [31:0]   bf_h_reg;	// black frame dot range
	reg [31:0]   bf_v_reg;	// black frame line range
	reg [31:0]   eff_h_reg;	// effective dot range
	reg [31:0]   eff_v_reg;	// effective line range
	reg [31:0]   win_h_reg;	// window dot range
	reg [31:0]   win_v_reg;	// window line range
	reg [31:0]   period_reg;	// period low, width high
	reg [5:0]    clip_reg;	// last clip flags, gain then bright

	// range fields
	function [CW-1:0] lo_f;
		input [31:0] r;
		begin
			lo_f = r[CW-1:0];
		end
	endfunction
	function [CW-1:0] hi_f;
		input [31:0] r;
		begin
			hi_f = r[`RANGE_STOP_LO+CW-1:`RANGE_STOP_LO];
		end
	endfunction
	// inclusive range test
	function in_f;
		input [CW-1:0] p;
		input [31:0]   r;
		begin
			in_f = (p >= lo_f(r)) && (p <= hi_f(r));
		end
	endfunction

	// apb decode and read mux
	wire        setup_w = psel & ~penable;	// setup phase
	wire        wr_w    = psel & penable & pready & pwrite;	// write edge
	reg  [31:0] rd_w;	// read value
	reg         hit_w;	// mapped address
	always @* begin
		hit_w = 1'b1;
		rd_w  = 32'h0000_0000;
		case (paddr)
		`OFS_CTRL:     rd_w = ctrl_reg;
		`OFS_GAIN:     rd_w = {8'h00, gain_reg[2], gain_reg[1], gain_reg[0]};
		`OFS_BRIGHT_R: rd_w = {21'h000000, bright_reg[0]};
		`OFS_BRIGHT_G: rd_w = {21'h000000, bright_reg[1]};
		`OFS_BRIGHT_B: rd_w = {21'h000000, bright_reg[2]};
		`OFS_BF_LEVEL: rd_w = {22'h000000, bf_level_reg};
		`OFS_BF_H:     rd_w = bf_h_reg;
		`OFS_BF_V:     rd_w = bf_v_reg;
		`OFS_MUTE_R:   rd_w = {22'h000000, mute_reg[0]};
		`OFS_MUTE_G:   rd_w = {22'h000000, mute_reg[1]};
		`OFS_MUTE_B:   rd_w = {22'h000000, mute_reg[2]};
		`OFS_EFF_H:    rd_w = eff_h_reg;
		`OFS_EFF_V:    rd_w = eff_v_reg;
		`OFS_WIN_H:    rd_w = win_h_reg;
		`OFS_WIN_V:    rd_w = win_v_reg;
		`OFS_LEVA_R:   rd_w = {22'h000000, leva_reg[0]};
		`OFS_LEVA_G:   rd_w = {22'h000000, leva_reg[1]};
		`OFS_LEVA_B:   rd_w = {22'h000000, leva_reg[2]};
		`OFS_LEVB_R:   rd_w = {22'h000000, levb_reg[0]};
		`OFS_LEVB_G:   rd_w = {22'h000000, levb_reg[1]};
		`OFS_LEVB_B:   rd_w = {22'h000000, levb_reg[2]};
		`OFS_PERIOD:   rd_w = period_reg;
		`OFS_STATUS:   rd_w = {26'h0000000, clip_reg};
		default:       hit_w = 1'b0;	// unmapped, error
		endcase
	end

	// apb answer: ready in the first access cycle
	always @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup_w;
			pslverr <= setup_w & ~hit_w;
			if (setup_w) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_w;
			end
		end
	end

	// register writes, mask keeps reserved bits zero
	integer i;
	always @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ctrl_reg     <= 32'h0000_0000;
			bf_level_reg <= `RST_LEVEL;
			bf_h_reg     <= 32'h0000_0000;
			bf_v_reg     <= 32'h0000_0000;
			eff_h_reg    <= 32'h0000_0000;
			eff_v_reg    <= 32'h0000_0000;
			win_h_reg    <= 32'h0000_0000;
			win_v_reg    <= 32'h0000_0000;
			period_reg   <= 32'h0000_0000;
			for (i = 0; i < 3; i = i + 1) begin
				gain_reg[i]   <= `RST_GAIN;
				bright_reg[i] <= `RST_BRIGHT;
				mute_reg[i]   <= `RST_LEVEL;
				leva_reg[i]   <= `RST_LEVEL;
				levb_reg[i]   <= `RST_LEVEL;
			end
		end else if (wr_w) begin
			case (paddr)
			`OFS_CTRL:     ctrl_reg <= pwdata & 32'h0000_77ff;
			`OFS_GAIN: begin
				gain_reg[0] <= pwdata[7:0];
				gain_reg[1] <= pwdata[15:8];
				gain_reg[2] <= pwdata[23:16];
			end
			`OFS_BRIGHT_R: bright_reg[0] <= pwdata[10:0];
			`OFS_BRIGHT_G: bright_reg[1] <= pwdata[10:0];
			`OFS_BRIGHT_B: bright_reg[2] <= pwdata[10:0];
			`OFS_BF_LEVEL: bf_level_reg <= pwdata[PW-1:0];
			`OFS_BF_H:     bf_h_reg <= pwdata & 32'h07ff_07ff;
			`OFS_BF_V:     bf_v_reg <= pwdata & 32'h07ff_07ff;
			`OFS_MUTE_R:   mute_reg[0] <= pwdata[PW-1:0];
			`OFS_MUTE_G:   mute_reg[1] <= pwdata[PW-1:0];
			`OFS_MUTE_B:   mute_reg[2] <= pwdata[PW-1:0];
			`OFS_EFF_H:    eff_h_reg <= pwdata & 32'h07ff_07ff;
			`OFS_EFF_V:    eff_v_reg <= pwdata & 32'h07ff_07ff;
			`OFS_WIN_H:    win_h_reg <= pwdata & 32'h07ff_07ff;
			`OFS_WIN_V:    win_v_reg <= pwdata & 32'h07ff_07ff;
			`OFS_LEVA_R:   leva_reg[0] <= pwdata[PW-1:0];
			`OFS_LEVA_G:   leva_reg[1] <= pwdata[PW-1:0];
			`OFS_LEVA_B:   leva_reg[2] <= pwdata[PW-1:0];
			`OFS_LEVB_R:   levb_reg[0] <= pwdata[PW-1:0];
			`OFS_LEVB_G:   levb_reg[1] <= pwdata[PW-1:0];
			`OFS_LEVB_B:   levb_reg[2] <= pwdata[PW-1:0];
			`OFS_PERIOD:   period_reg <= pwdata & 32'h07ff_07ff;
			default: ;	// read-only or unmapped
			endcase
		end
	end

	// control fields
	wire       bf_en_w    = ctrl_reg[`CTRL_BF_EN];
	wire       mute_en_w  = ctrl_reg[`CTRL_MUTE_EN];
	wire       pat_en_w   = ctrl_reg[`CTRL_PAT_EN];
	wire [2:0] col_en_w   = ctrl_reg[`CTRL_COL_EN_LO+2:`CTRL_COL_EN_LO];
	wire [2:0] swap_w     = ctrl_reg[`CTRL_SWAP_LO+2:`CTRL_SWAP_LO];
	wire       diag_w     = ctrl_reg[`CTRL_DIAG];
	wire       stair_w    = ctrl_reg[`CTRL_STAIR];
	wire [2:0] code_w     = ctrl_reg[`CTRL_CODE_LO+2:`CTRL_CODE_LO];
	wire [CW-1:0] per_w   = lo_f(period_reg);	// repeat period
	wire [CW-1:0] width_w = hi_f(period_reg);	// element width

	// phase advance with wrap at the period
	function [CW-1:0] wrap_f;
		input [CW-1:0] ph;
		input [CW-1:0] per;
		begin
			wrap_f = (ph + 1'b1 >= per) ? {CW{1'b0}} : ph + 1'b1;
		end
	endfunction

	// stripe phases inside the window
	reg  [CW-1:0] hph_reg;	// dot phase
	reg  [CW-1:0] lph_reg;	// line phase of current line
	reg  [CW-1:0] dph_reg;	// diagonal phase
	wire in_win_w  = in_f(dot_pos, win_h_reg) && in_f(line_pos, win_v_reg);
	wire in_eff_w  = in_f(dot_pos, eff_h_reg) && in_f(line_pos, eff_v_reg);
	wire first_w   = (dot_pos == lo_f(win_h_reg));	// first window dot
	wire [CW-1:0] lph_next = (line_pos == lo_f(win_v_reg)) ? {CW{1'b0}} :
		wrap_f(lph_reg, per_w);
	wire [CW-1:0] cur_h = first_w ? {CW{1'b0}} : hph_reg;
	wire [CW-1:0] cur_v = first_w ? lph_next : lph_reg;
	wire [CW-1:0] cur_d = first_w ? cur_v : dph_reg;

	// dot and diagonal phases advance once per window pixel, line phase once per window line
	always @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			hph_reg <= {CW{1'b0}};
			lph_reg <= {CW{1'b0}};
			dph_reg <= {CW{1'b0}};
		end else if (pix_valid && in_win_w) begin
			hph_reg <= wrap_f(cur_h, per_w);
			dph_reg <= wrap_f(cur_d, per_w);
			if (first_w) begin
				lph_reg <= lph_next;
			end
		end
	end

	// element hits
	wire on_h_w = cur_h < width_w;	// vertical stripe dot
	wire on_v_w = cur_v < width_w;	// horizontal stripe line
	wire on_d_w = cur_d < width_w;	// diagonal stripe dot
	wire [CW-1:0] rel_h_w = dot_pos - lo_f(win_h_reg);	// window dot
	wire [CW-1:0] rel_v_w = line_pos - lo_f(win_v_reg);	// window line

	// pattern hit and gradient selection
	reg          pat_hit_w;	// pattern pixel
	reg          grad_w;	// gradient overrides levels
	reg [PW-1:0] grad_lvl_w;	// gradient level
	always @* begin
		pat_hit_w  = 1'b0;
		grad_w     = 1'b0;
		grad_lvl_w = {PW{1'b0}};
		case (code_w)
		`PAT_RASTER:  pat_hit_w = 1'b1;
		`PAT_WINDOW:  pat_hit_w = in_win_w;
		`PAT_VSTRIPE: pat_hit_w = in_win_w & (diag_w ? on_d_w : on_h_w);
		`PAT_HSTRIPE: pat_hit_w = in_win_w & on_v_w;
		`PAT_CROSS:   pat_hit_w = in_win_w & (on_h_w | on_v_w);
		`PAT_DOTS:    pat_hit_w = in_win_w & on_h_w & on_v_w;
		`PAT_HRAMP: begin
			grad_w     = in_win_w;
			grad_lvl_w = stair_w ? {rel_h_w[9:6], 6'h00} : rel_h_w[9:0];
		end
		`PAT_VRAMP: begin
			grad_w     = in_win_w;
			grad_lvl_w = stair_w ? {rel_v_w[8:5], 6'h00} : rel_v_w[9:0];
		end
		default: pat_hit_w = 1'b0;
		endcase
	end

	// white-balance gain: round with bit 5, clip on top two bits
	function [PW-1:0] gain_f;
		input [PW-1:0] p;
		input [7:0]    c;
		reg   [17:0]   prod;
		reg   [12:0]   mid;
		reg   [11:0]   rnd;
		begin
			prod = p * c;
			mid  = prod[17:5];
			rnd  = mid[12:1] + {11'h000, mid[0]};
			gain_f = (rnd[11:10] != 2'b00) ? {PW{1'b1}} : rnd[9:0];
		end
	endfunction
	function gclip_f;
		input [PW-1:0] p;
		input [7:0]    c;
		reg   [17:0]   prod;
		reg   [11:0]   rnd;
		begin
			prod = p * c;
			rnd  = prod[17:6] + {11'h000, prod[5]};
			gclip_f = (rnd[11:10] != 2'b00);
		end
	endfunction

	// white-balance bright: bit 10 selects subtract of a two's complement
	function [PW:0] bright_f;	// msb is clip flag
		input [PW-1:0] p;
		input [10:0]   b;
		reg   [PW:0]   sum;
		begin
			sum = {1'b0, p} + {1'b0, b[9:0]};
			if (!b[10]) begin	// add
				bright_f = sum[PW] ? {1'b1, {PW{1'b1}}} : {1'b0, sum[PW-1:0]};
			end else begin	// subtract, underflow without carry
				bright_f = sum[PW] ? {1'b0, sum[PW-1:0]} : {1'b1, {PW{1'b0}}};
			end
		end
	endfunction

	// pipeline, stage order gain, bright, final selection
	wire [3*PW-1:0] pin_w = {pix_in_b, pix_in_g, pix_in_r};
	reg  [3*PW-1:0] s1_reg;	// after gain
	reg  [3*PW-1:0] s2_reg;	// after bright
	reg  [3*PW-1:0] pl1_reg;	// pattern levels, stage 1
	reg  [3*PW-1:0] pl2_reg;	// pattern levels, stage 2
	reg  [1:0]      v_reg;	// valid per stage
	reg  [1:0]      bf_reg;	// black frame hit per stage
	reg  [3*PW-1:0] pl_w;	// pattern level per colour
	reg  [3*PW-1:0] s1_next;	// gain results
	reg  [3*PW-1:0] s2_next;	// bright results
	reg  [5:0]      clip_next;	// clip flags
	reg  [PW:0]     br_t;	// bright scratch
	integer k;
	always @* begin
		pl_w      = {3*PW{1'b0}};
		s1_next   = {3*PW{1'b0}};
		s2_next   = {3*PW{1'b0}};
		clip_next = 6'h00;
		br_t      = {PW+1{1'b0}};
		for (k = 0; k < 3; k = k + 1) begin
			s1_next[k*PW +: PW] = gain_f(pin_w[k*PW +: PW], gain_reg[k]);
			clip_next[k] = gclip_f(pin_w[k*PW +: PW], gain_reg[k]);
			br_t = bright_f(s1_reg[k*PW +: PW], bright_reg[k]);
			s2_next[k*PW +: PW] = br_t[PW-1:0];
			clip_next[k+3] = br_t[PW];
			if (!col_en_w[k] || !in_eff_w) begin
				pl_w[k*PW +: PW] = {PW{1'b0}};
			end else if (grad_w) begin
				pl_w[k*PW +: PW] = grad_lvl_w;
			end else if (pat_hit_w ^ swap_w[k]) begin
				pl_w[k*PW +: PW] = leva_reg[k];
			end else begin
				pl_w[k*PW +: PW] = levb_reg[k];
			end
		end
	end

	// first two pipeline stages
	always @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			s1_reg   <= {3*PW{1'b0}};
			s2_reg   <= {3*PW{1'b0}};
			pl1_reg  <= {3*PW{1'b0}};
			pl2_reg  <= {3*PW{1'b0}};
			v_reg    <= 2'b00;
			bf_reg   <= 2'b00;
			clip_reg <= 6'h00;
		end else begin
			s1_reg  <= s1_next;
			s2_reg  <= s2_next;
			pl1_reg <= pl_w;
			pl2_reg <= pl1_reg;
			v_reg   <= {v_reg[0], pix_valid};
			bf_reg  <= {bf_reg[0], in_f(dot_pos, bf_h_reg) &
				in_f(line_pos, bf_v_reg)};
			if (pix_valid) begin
				clip_reg[2:0] <= clip_next[2:0];
			end
			if (v_reg[0]) begin
				clip_reg[5:3] <= clip_next[5:3];
			end
		end
	end

	// final stage: pattern over mute over black frame over video
	always @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			out_valid <= 1'b0;
			pix_out_r <= {PW{1'b0}};
			pix_out_g <= {PW{1'b0}};
			pix_out_b <= {PW{1'b0}};
		end else begin
			out_valid <= v_reg[1];
			if (pat_en_w) begin
				pix_out_r <= pl2_reg[PW-1:0];
				pix_out_g <= pl2_reg[2*PW-1:PW];
				pix_out_b <= pl2_reg[3*PW-1:2*PW];
			end else if (mute_en_w) begin
				pix_out_r <= mute_reg[0];
				pix_out_g <= mute_reg[1];
				pix_out_b <= mute_reg[2];
			end else if (bf_en_w && bf_reg[1]) begin
				pix_out_r <= bf_level_reg;
				pix_out_g <= bf_level_reg;
				pix_out_b <= bf_level_reg;
			end else begin
				pix_out_r <= s2_reg[PW-1:0];
				pix_out_g <= s2_reg[2*PW-1:PW];
				pix_out_b <= s2_reg[3*PW-1:2*PW];
			end
		end
	end

endmodule // wb_pattern
`default_nettype wire

// ==== wb_pattern_props.sv ====
/* assertion checker for the white-balance and pattern block.
 * assumes apb master and pixel source keep the hand-over contract. */
`timescale 1ns/1ps
`default_nettype none
module wb_pattern_props #(
	parameter PW = 10,	// pixel width
	parameter CW = 11	// position width
) (
	input wire logic          clk,       // pixel clock
	input wire logic          arst_n,    // async reset, active low
	input wire logic          psel,      // apb select
	input wire logic          penable,   // apb access phase
	input wire logic          pwrite,    // apb write
	input wire logic [7:0]    paddr,     // apb address
	input wire logic [31:0]   pwdata,    // apb write data
	input wire logic [31:0]   prdata,    // apb read data
	input wire logic          pready,    // apb ready
	input wire logic          pslverr,   // apb error
	input wire logic          pix_valid, // pixel qualifier in
	input wire logic          out_valid, // pixel qualifier out
	input wire logic [PW-1:0] pix_out_r, // red out
	input wire logic [PW-1:0] pix_out_g, // green out
	input wire logic [PW-1:0] pix_out_b  // blue out
);
	logic [15:0] ctrl_reg;	// shadow of control low half

	// follow control writes at the completing edge
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			ctrl_reg <= 16'h0000;
		else if (psel && penable && pready && pwrite && paddr == 8'h00)
			ctrl_reg <= pwdata[15:0];
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// setup phase of a transfer
	sequence apb_setup;
		psel && !penable;
	endsequence
	// pattern on, all colours off, held through the pipe
	sequence pat_dark;
		(ctrl_reg[2] && ctrl_reg[5:3] == 3'h0)[*4] ##0 out_valid;
	endsequence

	valid_pipe_a: assert property (
		out_valid == $past(pix_valid, 3))
		else $error("output qualifier not three cycles behind");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("ready outside an access phase");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	setup_answer_a: assert property (apb_setup |=> pready)
		else $error("no answer in first access cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	unmapped_err_a: assert property (
		apb_setup ##0 (paddr > 8'h58 || paddr[1:0] != 2'b00) |=> pslverr)
		else $error("unmapped address not refused");
	mapped_ok_a: assert property (
		apb_setup ##0 (paddr <= 8'h58 && paddr[1:0] == 2'b00) |=> !pslverr)
		else $error("mapped address refused");
	rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved outside a transfer");
	colour_off_a: assert property (
		pat_dark |-> {pix_out_r, pix_out_g, pix_out_b} == '0)
		else $error("disabled pattern colour not at zero");
endmodule // wb_pattern_props

bind wb_pattern wb_pattern_props #(.PW(PW), .CW(CW)) u_props (
	.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pix_valid(pix_valid),
	.out_valid(out_valid), .pix_out_r(pix_out_r), .pix_out_g(pix_out_g),
	.pix_out_b(pix_out_b));
`default_nettype wire

// ==== video_source.sv ====
/* upstream pixel source: one raster frame of H x V dots per run.
 * assumes run is held high until done rises, then dropped. */
`timescale 1ns/1ps
`default_nettype none
module video_source #(
	parameter H = 72,	// active dots per line
	parameter V = 36	// lines per frame
) (
	input  wire logic        clk,       // pixel clock
	input  wire logic        run,       // scan while high
	output var  logic        done,      // frame finished
	output wire logic        pix_valid, // active dot
	output wire logic [9:0]  pix_r,     // red pixel
	output wire logic [9:0]  pix_g,     // green pixel
	output wire logic [9:0]  pix_b,     // blue pixel
	output var  logic [10:0] dot,       // dot position
	output var  logic [10:0] line       // line position
);
	// scan counters, four blank dots end every line
	always @(posedge clk) begin
		if (!run) begin
			dot <= 11'h000;
			line <= 11'h000;
			done <= 1'b0;
		end else if (dot == H + 3) begin
			dot <= 11'h000;
			if (line == V - 1)
				done <= 1'b1;
			else
				line <= line + 11'h001;
		end else
			dot <= dot + 11'h001;
	end
	// data follows position, so it moves in blanking as well
	assign pix_valid = run && !done && dot < H;
	assign pix_r = 10'(dot * 13 + line * 7);
	assign pix_g = 10'(dot * 29 + line * 3);
	assign pix_b = ~10'(dot * 5 + line * 41);
endmodule // video_source
`default_nettype wire

// ==== testbench.sv ====
/* self-checking bench: apb register access and frames of video.
 * assumes the block, its defines header, checker and pixel source. */
`timescale 1ns/1ps
`default_nettype none
`include "wb_pattern_defines.vh"
module testbench;
	logic        clk, arst_n;                   // clock, reset
	logic        psel, penable, pwrite;         // apb request
	logic [7:0]  paddr;                         // apb address
	logic [31:0] pwdata, prdata, rdat;          // apb data
	logic        pready, pslverr, rerr;         // apb answer
	logic        run, done, pix_valid, out_valid;
	logic [9:0]  pix_in_r, pix_in_g, pix_in_b;  // pixels in
	logic [9:0]  pix_out_r, pix_out_g, pix_out_b;
	logic [10:0] dot_pos, line_pos;             // positions
	logic [31:0] rg [0:22];                     // register shadow
	logic [29:0] ep [0:3];                      // expected pixel pipe
	logic        ev [0:3];                      // expected valid pipe
	logic        armed;                         // output check on
	int          error_cnt, n_checks;

	wb_pattern dut (.clk(clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pix_valid(pix_valid), .pix_in_r(pix_in_r),
		.pix_in_g(pix_in_g), .pix_in_b(pix_in_b), .dot_pos(dot_pos),
		.line_pos(line_pos), .out_valid(out_valid),
		.pix_out_r(pix_out_r), .pix_out_g(pix_out_g),
		.pix_out_b(pix_out_b));
	video_source src (.clk(clk), .run(run), .done(done),
		.pix_valid(pix_valid), .pix_r(pix_in_r), .pix_g(pix_in_g),
		.pix_b(pix_in_b), .dot(dot_pos), .line(line_pos));

	// 100 mhz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h, expected %h", $time,
				got, exp);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d, errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// one apb transfer, held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int t;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		rdat = prdata;
		rerr = pslverr;
		if (t >= 20)
			chk(pready, 1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// write, keep the shadow, read back
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		rg[a[7:2]] = d;
		apb(1'b0, a, 32'h0);
		chk(rdat, d);
		chk(rerr, 0);
	endtask

	// one full frame from the source, then let the pipe drain
	task automatic frame;
		int t;
		@(posedge clk);
		run <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (done !== 1'b1 && t < 4000);
		chk(done, 1);
		run <= 1'b0;
		repeat (6) @(posedge clk);
	endtask

	function automatic logic inr(input logic [10:0] a, input logic [31:0] r);
		return a >= r[10:0] && a <= r[26:16];
	endfunction

	// expected output of one colour for one input pixel
	function automatic logic [9:0] expv(input int c, input logic [9:0] p,
		input logic [10:0] d, input logic [10:0] l);
		logic [17:0] m;
		logic [11:0] s;
		logic [10:0] t, x, y, hp, vp, per, wid;
		logic [9:0]  v, g;
		logic [15:0] k;
		logic        on, w;
		k = rg[0][15:0];
		m = p * rg[1][8*c +: 8];
		s = m[17:6] + m[5];
		v = (s[11:10] != 2'b00) ? 10'h3ff : s[9:0];
		t = {1'b0, v} + rg[2+c][9:0];
		if (!rg[2+c][10])
			v = t[10] ? 10'h3ff : t[9:0];
		else
			v = t[10] ? t[9:0] : 10'h000;
		if (k[0] && inr(d, rg[6]) && inr(l, rg[7]))
			v = rg[5][9:0];
		if (k[1])
			v = rg[8+c][9:0];
		if (!k[2])
			return v;
		x = d - rg[13][10:0];
		y = l - rg[14][10:0];
		w = inr(d, rg[13]) && inr(l, rg[14]);
		per = rg[21][10:0];
		wid = rg[21][26:16];
		hp = x % per;
		vp = y % per;
		on = 1'b0;
		g = k[10] ? {x[9:6], 6'h00} : x[9:0];
		case (k[14:12])
			3'h0: on = 1'b1;
			3'h1: on = w;
			3'h2: on = w && ((k[9] ? (hp + vp) % per : hp) < wid);
			3'h3: on = w && vp < wid;
			3'h4: on = w && (hp < wid || vp < wid);
			3'h5: on = w && hp < wid && vp < wid;
			3'h7: g = k[10] ? {y[8:5], 6'h00} : y[9:0];
			default: on = 1'b0;
		endcase
		v = (on ^ k[6+c]) ? rg[15+c][9:0] : rg[18+c][9:0];
		if (k[14:13] == 2'b11 && w)
			v = g;
		if (!k[3+c] || !inr(d, rg[11]) || !inr(l, rg[12]))
			v = 10'h000;
		return v;
	endfunction

	// downstream sink: compare three edges after the pixel was taken
	always @(posedge clk) begin
		if (armed) begin
			chk(out_valid, ev[2]);
			if (ev[2])
				chk({pix_out_r, pix_out_g, pix_out_b}, ep[2]);
		end
		for (int i = 3; i > 0; i--) begin
			ev[i] = ev[i-1];
			ep[i] = ep[i-1];
		end
		ev[0] = pix_valid;
		ep[0] = {expv(0, pix_in_r, dot_pos, line_pos),
			expv(1, pix_in_g, dot_pos, line_pos),
			expv(2, pix_in_b, dot_pos, line_pos)};
	end

	// reset values and refused addresses
	task automatic t_regs;
		for (int i = 0; i < 23; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk(rdat, rg[i]);
		end
		apb(1'b1, 8'h5c, 32'hffffffff);
		chk(rerr, 1);
		apb(1'b0, 8'h5c, 32'h0);
		chk(rerr, 1);
		chk(rdat, 0);
	endtask

	// gain rounding and clipping, bright add and subtract clipping
	task automatic t_video;
		logic [31:0] gains [2] = '{32'h0021ff40, 32'h007f8000};
		logic [10:0] brs [6] = '{11'h005, 11'h6d4, 11'h3ff,
			11'h400, 11'h7ff, 11'h000};
		for (int i = 0; i < 2; i++) begin
			wr(`OFS_GAIN, gains[i]);
			for (int c = 0; c < 3; c++)
				wr(8'(`OFS_BRIGHT_R + 4 * c), {21'h0, brs[3*i+c]});
			frame;
		end
	endtask

	// black frame over a range, then mute above it
	task automatic t_frame_mute;
		wr(`OFS_BF_LEVEL, 32'h155);
		wr(`OFS_BF_H, 32'h0028000a);
		wr(`OFS_BF_V, 32'h001e0005);
		wr(`OFS_CTRL, 32'h1);
		frame;
		for (int c = 0; c < 3; c++)
			wr(8'(`OFS_MUTE_R + 4 * c), 32'h3ff >> (c * 4));
		wr(`OFS_CTRL, 32'h3);
		frame;
	endtask

	// every pattern code, swaps, stripe and stair variants
	task automatic t_pattern;
		logic [15:0] tbl [13] = '{16'h00bf, 16'h117f, 16'h20bf, 16'h317f,
			16'h40bf, 16'h517f, 16'h60bf, 16'h717f, 16'h237f, 16'h64bf,
			16'h757f, 16'h0097, 16'h0087};
		wr(`OFS_EFF_H, 32'h00450002);
		wr(`OFS_EFF_V, 32'h00220001);
		wr(`OFS_WIN_H, 32'h00410000);
		wr(`OFS_WIN_V, 32'h00210000);
		wr(`OFS_PERIOD, 32'h00030007);
		for (int c = 0; c < 3; c++) begin
			wr(8'(`OFS_LEVA_R + 4 * c), 32'h3c0 - 32'(c * 'h111));
			wr(8'(`OFS_LEVB_R + 4 * c), 32'h05a + 32'(c * 'h0c3));
		end
		for (int i = 0; i < 13; i++) begin
			wr(`OFS_CTRL, {16'h0, tbl[i]});
			frame;
		end
	endtask

	// main sequence
	initial begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		run = 1'b0;
		armed = 1'b0;
		error_cnt = 0;
		n_checks = 0;
		for (int i = 0; i < 23; i++)
			rg[i] = 32'h0;
		rg[1] = 32'h00404040;
		for (int i = 0; i < 4; i++)
			ev[i] = 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (6) @(posedge clk);
		armed = 1'b1;
		t_regs;
		t_video;
		t_frame_mute;
		t_pattern;
		give_verdict;
	end

	// watchdog, well beyond the expected run length
	initial begin
		#800000;
		error_cnt++;
		give_verdict;
	end
endmodule // testbench
`default_nettype wire
